// file: pkg/txa_pkg.sv
package txa_pkg;

    // --------------------------------------------------------------
    // Sizing
    // --------------------------------------------------------------
    localparam int BUF_COUNT = 8;
    localparam int IDX_W = 3;
    localparam int PRIO_W = 3;
    localparam int ADDR_W = 5;
    localparam int WORD_W = 32;
    localparam int RETR_W = 4;

    // --------------------------------------------------------------
    // Word offsets inside one transmit buffer
    // --------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADR_FORMAT = 5'h00;
    localparam logic [ADDR_W-1:0] ADR_IDENT = 5'h01;
    localparam logic [ADDR_W-1:0] ADR_TS_LOW = 5'h02;
    localparam logic [ADDR_W-1:0] ADR_TS_HIGH = 5'h03;

    // Reset values
    localparam logic [IDX_W-1:0] IDX_RESET = 3'h0;
    localparam logic [RETR_W-1:0] RETR_RESET = 4'h0;
    localparam logic [WORD_W-1:0] WORD_RESET = 32'h00000000;

    // Per-buffer state codes
    typedef enum logic [3:0] {
        BUF_EMPTY = 4'h1,
        BUF_READY = 4'h2,
        BUF_TX_PROG = 4'h4,
        BUF_DONE = 4'h8
    } txa_buf_state_t;

    // Arbitrator state codes
    typedef enum logic [4:0] {
        ARB_IDLE = 5'h01,
        ARB_FORMAT = 5'h02,
        ARB_IDENT = 5'h04,
        ARB_STAMP = 5'h08,
        ARB_LOCKED = 5'h10
    } txa_arb_state_t;

    // Commands from the protocol engine
    typedef struct packed {
        logic lock;
        logic unlock_retry;
        logic unlock_done;
    } txa_cmd_t;

    // Captured frame header seen by the protocol engine
    typedef struct packed {
        logic [WORD_W-1:0] format;
        logic [WORD_W-1:0] ident;
    } txa_meta_t;

endpackage

// file: verilog/txa_prio_decoder.sv
`timescale 1ns/100ps
module txa_prio_decoder #(
    parameter int COUNT = txa_pkg::BUF_COUNT
) (
    input wire logic [COUNT-1:0] avail,
    input wire logic [COUNT*txa_pkg::PRIO_W-1:0] prio,
    output logic found,
    output logic [txa_pkg::IDX_W-1:0] index
);

    // ------------------------------------------------------------
    // Selection
    // ------------------------------------------------------------
    // Strict greater-than keeps the lower index on a tie
    always_comb
    begin
        logic [txa_pkg::PRIO_W-1:0] best;
        best = '0;
        found = 1'b0;
        index = txa_pkg::IDX_RESET;
        for (int i = 0; i < COUNT; i++)
        begin
            if (avail[i] && (!found ||
                prio[i*txa_pkg::PRIO_W +: txa_pkg::PRIO_W] > best))
            begin
                found = 1'b1;
                best = prio[i*txa_pkg::PRIO_W +: txa_pkg::PRIO_W];
                index = i[txa_pkg::IDX_W-1:0];
            end
        end
    end

endmodule // txa_prio_decoder

// file: verilog/txa_arbitrator.sv
`timescale 1ns/100ps
// Contract
// - Set-ready on empty buffer makes it available
// - Validated signals pending; lock marks buffer used
// - Retry unlock returns buffer ready, counter increments
// - Highest priority available buffer is selected
// - Lock on different buffer clears retry counter
// - Re-evaluate selection when priorities or states change
// - Lock wins over coincident selection change
// - Lock during validation skips capture load
// - Validation drives format, identifier, timestamp addresses
// - Locked: hold index, pass engine address, mux
// - Each data word carries four data bytes
// - Header comes from capture registers, not RAM
// - Ties pick lower index; none means idle
module txa_arbitrator #(
    parameter int COUNT = txa_pkg::BUF_COUNT
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [COUNT-1:0] set_ready,
    input wire logic [COUNT-1:0] set_abort,
    input wire logic [COUNT*txa_pkg::PRIO_W-1:0] prio,
    input wire txa_pkg::txa_cmd_t cmd,
    input wire logic [txa_pkg::ADDR_W-1:0] engine_addr,
    input wire logic [COUNT*txa_pkg::WORD_W-1:0] ram_rdata,
    output logic [txa_pkg::ADDR_W-1:0] ram_addr,
    output logic [txa_pkg::IDX_W-1:0] ram_index,
    output logic [txa_pkg::WORD_W-1:0] data_word,
    output logic frame_valid,
    output txa_pkg::txa_meta_t meta,
    output logic [txa_pkg::IDX_W-1:0] used_index,
    output logic [COUNT-1:0] buf_ready,
    output logic [COUNT-1:0] buf_in_tx,
    output logic [txa_pkg::RETR_W-1:0] retr_count
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    txa_pkg::txa_arb_state_t arb_q;
    txa_pkg::txa_buf_state_t buf_q [COUNT];
    logic [COUNT-1:0] avail;
    logic sel_found;
    logic [txa_pkg::IDX_W-1:0] sel_index;
    logic [txa_pkg::IDX_W-1:0] val_index_q;
    logic [txa_pkg::IDX_W-1:0] used_q;
    logic [txa_pkg::IDX_W-1:0] last_q;
    logic validated_q;
    logic [txa_pkg::WORD_W-1:0] fmt_shadow_q;
    txa_pkg::txa_meta_t meta_q;
    logic [txa_pkg::RETR_W-1:0] retr_q;
    logic [txa_pkg::WORD_W-1:0] word_q;
    logic [txa_pkg::WORD_W-1:0] rd_mux;
    logic stamp_hi_q;
    logic sel_changed;
    logic lock_now;
    logic unlock_now;

    assign lock_now = cmd.lock && arb_q != txa_pkg::ARB_IDLE;
    assign unlock_now = (cmd.unlock_retry || cmd.unlock_done) &&
        arb_q == txa_pkg::ARB_LOCKED;
    // Restart validation whenever the winner moves away
    assign sel_changed = !sel_found || sel_index != val_index_q;

    // ------------------------------------------------------------
    // Per-buffer state machines
    // ------------------------------------------------------------
    generate
        for (genvar g = 0; g < COUNT; g++)
        begin : gen_buf
            always_ff @(posedge clock)
            begin
                if (rst)
                    buf_q[g] <= txa_pkg::BUF_EMPTY;
                else if (set_abort[g] && buf_q[g] != txa_pkg::BUF_TX_PROG)
                    buf_q[g] <= txa_pkg::BUF_EMPTY;
                else
                begin
                    unique case (buf_q[g])
                        txa_pkg::BUF_EMPTY, txa_pkg::BUF_DONE:
                            if (set_ready[g])
                                buf_q[g] <= txa_pkg::BUF_READY;
                        txa_pkg::BUF_READY:
                            if (lock_now && val_index_q == g)
                                buf_q[g] <= txa_pkg::BUF_TX_PROG;
                        txa_pkg::BUF_TX_PROG:
                            if (unlock_now && used_q == g)
                                buf_q[g] <= cmd.unlock_retry ?
                                    txa_pkg::BUF_READY :
                                    txa_pkg::BUF_DONE;
                        default:
                            buf_q[g] <= txa_pkg::BUF_EMPTY;
                    endcase
                end
            end
            // Abort cuts availability in the same cycle
            assign avail[g] = buf_q[g] == txa_pkg::BUF_READY &&
                !set_abort[g];
            assign buf_ready[g] = buf_q[g] == txa_pkg::BUF_READY;
            assign buf_in_tx[g] = buf_q[g] == txa_pkg::BUF_TX_PROG;
        end
    endgenerate

    txa_prio_decoder #(
        .COUNT(COUNT)
    ) u_dec (
        .avail(avail),
        .prio(prio),
        .found(sel_found),
        .index(sel_index)
    );

    // ------------------------------------------------------------
    // Arbitrator state machine
    // ------------------------------------------------------------
    // Lock is checked first so it beats any selection change
    always_ff @(posedge clock)
    begin
        if (rst)
            arb_q <= txa_pkg::ARB_IDLE;
        else if (lock_now && arb_q != txa_pkg::ARB_LOCKED)
            arb_q <= txa_pkg::ARB_LOCKED;
        else
        begin
            unique case (arb_q)
                txa_pkg::ARB_IDLE:
                    if (sel_found)
                        arb_q <= txa_pkg::ARB_FORMAT;
                txa_pkg::ARB_FORMAT:
                    arb_q <= sel_changed ? txa_pkg::ARB_IDLE :
                        txa_pkg::ARB_IDENT;
                txa_pkg::ARB_IDENT:
                    arb_q <= sel_changed ? txa_pkg::ARB_IDLE :
                        txa_pkg::ARB_STAMP;
                txa_pkg::ARB_STAMP:
                    if (sel_changed)
                        arb_q <= txa_pkg::ARB_IDLE;
                txa_pkg::ARB_LOCKED:
                    if (unlock_now)
                        arb_q <= txa_pkg::ARB_IDLE;
                default:
                    arb_q <= txa_pkg::ARB_IDLE;
            endcase
        end
    end

    // Index under validation is loaded from the decoder in idle only
    always_ff @(posedge clock)
    begin
        if (rst)
            val_index_q <= txa_pkg::IDX_RESET;
        else if (arb_q == txa_pkg::ARB_IDLE && sel_found)
            val_index_q <= sel_index;
    end

    // Validated flag: set once header words are captured
    always_ff @(posedge clock)
    begin
        if (rst)
            validated_q <= 1'b0;
        else if (lock_now || unlock_now)
            validated_q <= lock_now;
        else if (arb_q == txa_pkg::ARB_LOCKED)
            validated_q <= 1'b1;
        else if (sel_changed)
            validated_q <= 1'b0;
        else if (arb_q == txa_pkg::ARB_STAMP)
            validated_q <= 1'b1;
    end

    // Drops at once on abort of the validated buffer
    assign frame_valid = validated_q && (arb_q == txa_pkg::ARB_LOCKED ||
        !sel_changed);

    // ------------------------------------------------------------
    // Header capture, double buffered
    // ------------------------------------------------------------
    // Format goes to a hidden shadow first so that format and
    // identifier change together for the engine
    always_ff @(posedge clock)
    begin
        if (rst)
            fmt_shadow_q <= txa_pkg::WORD_RESET;
        else if (arb_q == txa_pkg::ARB_FORMAT && !sel_changed)
            fmt_shadow_q <= rd_mux;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            meta_q <= '0;
        else if (arb_q == txa_pkg::ARB_IDENT && !sel_changed && !lock_now)
            meta_q <= {fmt_shadow_q, rd_mux};
    end

    assign meta = meta_q;

    // ------------------------------------------------------------
    // Used buffer and retransmission counter
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst)
            used_q <= txa_pkg::IDX_RESET;
        else if (lock_now && arb_q != txa_pkg::ARB_LOCKED)
            used_q <= val_index_q;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            last_q <= txa_pkg::IDX_RESET;
        else if (lock_now && arb_q != txa_pkg::ARB_LOCKED)
            last_q <= val_index_q;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            retr_q <= txa_pkg::RETR_RESET;
        else if (lock_now && arb_q != txa_pkg::ARB_LOCKED &&
            val_index_q != last_q)
            retr_q <= txa_pkg::RETR_RESET;
        else if (unlock_now && cmd.unlock_retry)
            retr_q <= retr_q + 4'h1;
    end

    assign retr_count = retr_q;
    assign used_index = used_q;

    // ------------------------------------------------------------
    // RAM addressing and read mux
    // ------------------------------------------------------------
    always_comb
    begin
        unique case (arb_q)
            txa_pkg::ARB_FORMAT: ram_addr = txa_pkg::ADR_FORMAT;
            txa_pkg::ARB_IDENT: ram_addr = txa_pkg::ADR_IDENT;
            txa_pkg::ARB_STAMP: ram_addr = stamp_hi_q ?
                txa_pkg::ADR_TS_HIGH : txa_pkg::ADR_TS_LOW;
            txa_pkg::ARB_LOCKED: ram_addr = engine_addr;
            default: ram_addr = txa_pkg::ADR_TS_HIGH;
        endcase
    end

    assign ram_index = arb_q == txa_pkg::ARB_LOCKED ? used_q : val_index_q;
    assign rd_mux = ram_rdata[ram_index*txa_pkg::WORD_W +: txa_pkg::WORD_W];

    // Timestamp words alternate low, high while the stamp state waits;
    // both stay addressed so a later compare can use either half
    always_ff @(posedge clock)
    begin
        if (rst)
            stamp_hi_q <= 1'b0;
        else if (arb_q == txa_pkg::ARB_STAMP)
            stamp_hi_q <= !stamp_hi_q;
        else
            stamp_hi_q <= 1'b0;
    end

    // One RAM word feeds four data bytes to the shift register;
    // the engine addresses ahead to hide the read latency
    always_ff @(posedge clock)
    begin
        if (rst)
            word_q <= txa_pkg::WORD_RESET;
        else if (arb_q == txa_pkg::ARB_LOCKED)
            word_q <= rd_mux;
    end

    assign data_word = word_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_lock_enters: assert property (@(posedge clock) disable iff (rst)
        lock_now |=> arb_q == txa_pkg::ARB_LOCKED)
        else $error("lock did not lock");
    a_retry_incr: assert property (@(posedge clock) disable iff (rst)
        unlock_now && cmd.unlock_retry && !lock_now
        |=> retr_q == $past(retr_q) + 4'h1)
        else $error("retry count not incremented");
    a_retr_clear: assert property (@(posedge clock) disable iff (rst)
        lock_now && arb_q != txa_pkg::ARB_LOCKED && val_index_q != last_q
        |=> retr_q == txa_pkg::RETR_RESET)
        else $error("retry count not cleared");
    a_no_capture: assert property (@(posedge clock) disable iff (rst)
        lock_now |=> meta_q == $past(meta_q))
        else $error("capture loaded under lock");
    a_used_tx: assert property (@(posedge clock) disable iff (rst)
        lock_now && arb_q != txa_pkg::ARB_LOCKED |=> buf_in_tx[used_q])
        else $error("used buffer not in transmission");
    a_locked_addr: assert property (@(posedge clock) disable iff (rst)
        arb_q == txa_pkg::ARB_LOCKED |-> ram_addr == engine_addr &&
        ram_index == used_q)
        else $error("locked address not forwarded");
    a_unlock_idle: assert property (@(posedge clock) disable iff (rst)
        unlock_now && !lock_now |=> arb_q == txa_pkg::ARB_IDLE)
        else $error("unlock did not release");
    a_val_order: assert property (@(posedge clock) disable iff (rst)
        arb_q == txa_pkg::ARB_FORMAT && !sel_changed && !lock_now
        |=> arb_q == txa_pkg::ARB_IDENT && ram_addr == txa_pkg::ADR_IDENT)
        else $error("validation sequence broken");
    a_none_idle: assert property (@(posedge clock) disable iff (rst)
        arb_q == txa_pkg::ARB_IDLE && !sel_found && !lock_now
        |=> arb_q == txa_pkg::ARB_IDLE)
        else $error("validation started with none available");
    a_stamp_high: assert property (@(posedge clock) disable iff (rst)
        arb_q == txa_pkg::ARB_STAMP && !sel_changed && !lock_now &&
        ram_addr == txa_pkg::ADR_TS_LOW
        |=> ram_addr == txa_pkg::ADR_TS_HIGH)
        else $error("high timestamp word not fetched");

endmodule // txa_arbitrator

// file: testbench/txa_engine_model.sv
`timescale 1ns/100ps
// Protocol engine and buffer RAM stand-in
module txa_engine_model (
    input wire logic clock,
    input wire logic frame_valid,
    input wire logic [txa_pkg::ADDR_W-1:0] ram_addr,
    output txa_pkg::txa_cmd_t cmd,
    output logic [txa_pkg::ADDR_W-1:0] engine_addr,
    output logic [8*txa_pkg::WORD_W-1:0] ram_rdata
);
    logic locked;

    initial
    begin
        locked = 1'b0;
        cmd = '0;
        engine_addr = 5'h1F;
    end

    // Word contents tell buffer and address apart
    function automatic logic [31:0] word_of(int b, logic [4:0] a);
        word_of = {8'hC0, 5'h00, b[2:0], 11'h000, a};
    endfunction

    // Every buffer answers in the cycle its address is shown
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            ram_rdata[i*32 +: 32] = word_of(i, ram_addr);
    end

    // Lock only against a pending frame, never while idle
    task automatic do_lock();
        if (frame_valid === 1'b1)
        begin
            cmd.lock = 1'b1;
            locked = 1'b1;
        end
        @(negedge clock);
        cmd.lock = 1'b0;
    endtask

    // Lock while validation still runs; caller keeps it off idle
    task automatic early_lock();
        cmd.lock = 1'b1;
        locked = 1'b1;
        @(negedge clock);
        cmd.lock = 1'b0;
    endtask

    // Unlock only once locked; address goes stale afterwards
    task automatic do_unlock(logic retry);
        if (locked)
        begin
            cmd.unlock_retry = retry;
            cmd.unlock_done = !retry;
            locked = 1'b0;
        end
        @(negedge clock);
        cmd = '0;
        engine_addr = ~engine_addr;
    endtask

    // Word address is raised one word ahead of its bytes
    task automatic fetch(logic [4:0] a);
        engine_addr = a;
        @(negedge clock);
    endtask
endmodule // txa_engine_model

// file: testbench/tb_tx_buffer_arbitrator.sv
`timescale 1ns/100ps
module tb_tx_buffer_arbitrator;
    logic clock;
    logic rst;
    logic [7:0] set_ready;
    logic [7:0] set_abort;
    logic [23:0] prio;
    txa_pkg::txa_cmd_t cmd;
    logic [4:0] engine_addr, ram_addr;
    logic [255:0] ram_rdata;
    logic [2:0] ram_index, used_index;
    logic [31:0] data_word;
    logic frame_valid;
    txa_pkg::txa_meta_t meta;
    logic [7:0] buf_ready, buf_in_tx;
    logic [3:0] retr_count;
    int miscompares = 0;
    int n_checks = 0;

    always #5 clock = ~clock;

    txa_arbitrator dut (.clock(clock), .rst(rst), .set_ready(set_ready),
        .set_abort(set_abort), .prio(prio), .cmd(cmd),
        .engine_addr(engine_addr), .ram_rdata(ram_rdata),
        .ram_addr(ram_addr), .ram_index(ram_index), .data_word(data_word),
        .frame_valid(frame_valid), .meta(meta), .used_index(used_index),
        .buf_ready(buf_ready), .buf_in_tx(buf_in_tx),
        .retr_count(retr_count));

    txa_engine_model eng (.clock(clock), .frame_valid(frame_valid),
        .ram_addr(ram_addr), .cmd(cmd), .engine_addr(engine_addr),
        .ram_rdata(ram_rdata));

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(string what, logic [63:0] exp, logic [63:0] got);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic step();
        @(negedge clock);
    endtask

    task automatic ready(logic [7:0] mask);
        set_ready = mask;
        step();
        set_ready = '0;
    endtask

    // Non-blocking, so a lock raised in the same step sees the old winner
    task automatic set_prio(int b, logic [2:0] p);
        prio[b*3 +: 3] <= p;
    endtask

    // Bounded wait, so a stuck validation cannot hang the run
    task automatic wait_valid();
        for (int i = 0; i < 30; i++)
        begin
            if (frame_valid === 1'b1)
                return;
            step();
        end
        miscompares++;
        $display("[FAIL] frame_valid expected 1 seen %b", frame_valid);
        complete_run();
    endtask

    task automatic lock_on(int b);
        wait_valid();
        eng.do_lock();
        check("used_index", b, used_index);
    endtask

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_lock_retry();
        set_prio(1, 3'h2);
        ready(8'h02);
        check("buf_ready1", 1, buf_ready[1]);
        wait_valid();
        check("meta", {eng.word_of(1, 0), eng.word_of(1, 1)}, meta);
        eng.do_lock();
        check("used_index", 1, used_index);
        check("buf_in_tx1", 1, buf_in_tx[1]);
        for (int k = 0; k < 3; k++)
        begin
            eng.fetch(5'(4 + k));
            check("ram_addr", 4 + k, ram_addr);
            check("ram_index", 1, ram_index);
            check("data_word", eng.word_of(1, 5'(4 + k)), data_word);
        end
        check("meta_held", {eng.word_of(1, 0), eng.word_of(1, 1)}, meta);
        eng.do_unlock(1'b1);
        check("retr_count", 1, retr_count);
        check("buf_ready1", 1, buf_ready[1]);
        check("buf_in_tx1", 0, buf_in_tx[1]);
        lock_on(1);
        check("retr_same_buf", 1, retr_count);
        eng.do_unlock(1'b1);
        check("retr_count", 2, retr_count);
        $display("t_lock_retry done");
    endtask

    task automatic t_buffer_change();
        set_prio(2, 3'h6);
        ready(8'h04);
        lock_on(2);
        check("retr_cleared", 0, retr_count);
        eng.do_unlock(1'b1);
        check("retr_count", 1, retr_count);
        lock_on(2);
        eng.do_unlock(1'b0);
        lock_on(1);
        check("retr_cleared", 0, retr_count);
        eng.do_unlock(1'b0);
        $display("t_buffer_change done");
    endtask

    // Equal priorities, then a priority change in the same step as the lock
    task automatic t_tie_lock_change();
        set_prio(4, 3'h3);
        set_prio(5, 3'h3);
        ready(8'h30);
        wait_valid();
        set_prio(5, 3'h6);
        eng.do_lock();
        check("used_index", 4, used_index);
        check("meta_format", eng.word_of(4, 0), meta.format);
        eng.do_unlock(1'b0);
        lock_on(5);
        eng.do_unlock(1'b0);
        repeat (8) step();
        check("idle_valid", 0, frame_valid);
        $display("t_tie_lock_change done");
    endtask

    task automatic t_abort_prio();
        set_prio(6, 3'h7);
        ready(8'h40);
        wait_valid();
        set_abort = 8'h40;
        #1;
        check("abort_valid", 0, frame_valid);
        step();
        set_abort = '0;
        repeat (6) step();
        check("none_valid", 0, frame_valid);
        set_prio(7, 3'h1);
        set_prio(0, 3'h2);
        ready(8'h81);
        wait_valid();
        set_prio(7, 3'h5);
        repeat (2) step();
        lock_on(7);
        eng.do_unlock(1'b0);
        lock_on(0);
        eng.do_unlock(1'b0);
        $display("t_abort_prio done");
    endtask

    // Lock while the identifier is read, then a reset in mid-run
    task automatic t_early_lock();
        set_prio(3, 3'h4);
        ready(8'h08);
        step();
        check("addr_format", txa_pkg::ADR_FORMAT, ram_addr);
        step();
        check("addr_ident", txa_pkg::ADR_IDENT, ram_addr);
        eng.early_lock();
        check("early_used", 3, used_index);
        check("early_tx3", 1, buf_in_tx[3]);
        check("early_meta", {eng.word_of(0, 0), eng.word_of(0, 1)},
            meta);
        rst = 1'b1;
        eng.do_unlock(1'b0);
        rst = 1'b0;
        check("rst_tx", 0, buf_in_tx);
        check("rst_used", 0, used_index);
        check("rst_meta", 0, meta);
        step();
        check("rst_valid", 0, frame_valid);
        check("rst_ready", 0, buf_ready);
        $display("t_early_lock done");
    endtask

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial
    begin
        clock = 1'b0;
        rst = 1'b1;
        set_ready = '0;
        set_abort = '0;
        prio <= '0;
        repeat (5) step();
        rst = 1'b0;
        check("reset_valid", 0, frame_valid);
        check("reset_retr", 0, retr_count);
        t_lock_retry();
        t_buffer_change();
        t_tie_lock_change();
        t_abort_prio();
        t_early_lock();
        complete_run();
    end
endmodule // tb_tx_buffer_arbitrator
